// ---- verilog/lqdet_pkg.sv ----
// Package: constants and carriers for the connector liquid detection controller
`default_nettype none
package lqdet_pkg;
    localparam int          ADC_W          = 10;
    localparam int          CNT_W          = 16;
    localparam int          CLK_MHZ        = 20;
    // ------------------------------------------------------------
    // Settle time after switching the sensing circuitry
    // ------------------------------------------------------------
    localparam int          SETTLE_US      = 10;
    localparam int          SETTLE_CYC     = SETTLE_US * CLK_MHZ;
    localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(SETTLE_CYC);
    localparam logic [CNT_W-1:0] CNT_RST   = 16'h0000;
    localparam logic [7:0]  SMP_RST        = 8'h00;
    localparam logic [1:0]  PIN_SBU1       = 2'h0;
    localparam logic [1:0]  PIN_SBU2       = 2'h1;

    typedef struct packed {
        logic                det_en;
        logic                corr_en;
        logic [ADC_W-1:0]    thresh;
        logic [7:0]          burst_len;
        logic [CNT_W-1:0]    burst_gap;
    } lqdet_cfg_t;

    typedef struct packed {
        logic                liquid;
        logic                short_det;
        logic                pwr_off;
        logic                host_evt;
    } lqdet_stat_t;

    typedef struct packed {
        logic                req;
        logic                pin;
    } lqdet_adc_req_t;

    typedef struct packed {
        logic                valid;
        logic [ADC_W-1:0]    data;
    } lqdet_adc_rsp_t;
endpackage : lqdet_pkg
`default_nettype wire

// ---- verilog/lqdet_cmp.sv ----
// Comparator stage: registers a sample verdict against the threshold
`timescale 1ns/1ns
`default_nettype none
module lqdet_cmp (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic                       ce,
    input  wire lqdet_pkg::lqdet_adc_rsp_t  rsp,
    input  wire logic [lqdet_pkg::ADC_W-1:0] thresh,
    output logic                            hit_vld,
    output logic                            hit
);
    import lqdet_pkg::*;
    wire above = rsp.data > thresh;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hit_vld <= 1'b0;
            hit     <= 1'b0;
        end else if (ce) begin
            hit_vld <= rsp.valid;
            hit     <= rsp.valid & above;
        end
    end
endmodule : lqdet_cmp
`default_nettype wire

// ---- verilog/lqdet_ctrl.sv ----
// Liquid and short detection controller for the connector sideband pins
`timescale 1ns/1ns
`default_nettype none
module lqdet_ctrl (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic                       ce,
    input  wire lqdet_pkg::lqdet_cfg_t      cfg,
    input  wire lqdet_pkg::lqdet_adc_rsp_t  adc_rsp,
    output var lqdet_pkg::lqdet_adc_req_t   adc_req,
    output logic [1:0]                      sense_up,
    output logic [1:0]                      sense_dn,
    output var lqdet_pkg::lqdet_stat_t      stat
);
    import lqdet_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_GAP, ST_DRIVE, ST_SAMPLE, ST_WAIT, ST_EVAL
    } lqdet_st_t;

    lqdet_st_t          st_r, st_nxt;
    logic [CNT_W-1:0]   cnt_r;
    logic [7:0]         smp_r;
    logic               pin_r;
    logic               found_r;
    logic               hit_vld;
    logic               hit;

    // True on the edge that moves the sequencer into the given state
    function automatic logic enters(input lqdet_st_t cur, input lqdet_st_t nxt,
                                    input lqdet_st_t tgt);
        return (nxt == tgt) && (cur != tgt);
    endfunction : enters

    // ------------------------------------------------------------
    // Sample verdict
    // ------------------------------------------------------------
    lqdet_cmp u_cmp (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .rsp     (adc_rsp),
        .thresh  (cfg.thresh),
        .hit_vld (hit_vld),
        .hit     (hit)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // One burst is burst_len+1 pairs, first sideband pin then second
    wire cnt_done   = (cnt_r == CNT_RST);
    wire last_smp   = (smp_r >= cfg.burst_len) && pin_r;
    wire burst_hit  = found_r | (hit_vld & hit);
    // Corrosion mitigation stretches the gap between bursts once wet
    wire [CNT_W-1:0] gap_len = (cfg.corr_en && stat.liquid) ?
                                {cfg.burst_gap[CNT_W-2:0], 1'b1} : cfg.burst_gap;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE:   if (cfg.det_en) st_nxt = ST_GAP;
            ST_GAP:    if (cnt_done) st_nxt = ST_DRIVE;
            ST_DRIVE:  if (cnt_done) st_nxt = ST_SAMPLE;
            ST_SAMPLE: st_nxt = ST_WAIT;
            ST_WAIT:   if (hit_vld) st_nxt = last_smp ? ST_EVAL : ST_DRIVE;
            ST_EVAL:   st_nxt = ST_GAP;
            default:   st_nxt = ST_IDLE;
        endcase
        if (!cfg.det_en) st_nxt = ST_IDLE;
    end

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r    <= ST_IDLE;
            cnt_r   <= CNT_RST;
            smp_r   <= SMP_RST;
            pin_r   <= 1'b0;
            found_r <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
            if (enters(st_r, st_nxt, ST_GAP))
                cnt_r <= gap_len;
            else if (enters(st_r, st_nxt, ST_DRIVE))
                cnt_r <= SETTLE_CNT;
            else if (!cnt_done)
                cnt_r <= cnt_r - 16'h0001;
            if (st_r == ST_WAIT && hit_vld) begin
                pin_r <= ~pin_r;
                if (pin_r)
                    smp_r <= smp_r + 8'h01;
                if (hit)
                    found_r <= 1'b1;
            end
            if (st_r == ST_EVAL || st_nxt == ST_IDLE) begin
                smp_r   <= SMP_RST;
                pin_r   <= 1'b0;
                found_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Pins and status
    // ------------------------------------------------------------
    wire active = (st_r == ST_DRIVE) || (st_r == ST_SAMPLE) || (st_r == ST_WAIT);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            adc_req  <= '0;
            sense_up <= 2'h0;
            sense_dn <= 2'h3;
            stat     <= '0;
        end else if (ce) begin
            adc_req.req <= (st_nxt == ST_SAMPLE);
            adc_req.pin <= pin_r;
            if (active && cfg.det_en) begin
                sense_up <= pin_r ? 2'h2 : 2'h1;
                sense_dn <= pin_r ? 2'h1 : 2'h2;
            end else begin
                sense_up <= 2'h0;
                sense_dn <= 2'h3;
            end
            stat.host_evt <= 1'b0;
            if (!cfg.det_en) begin
                stat.liquid    <= 1'b0;
                stat.short_det <= 1'b0;
                stat.pwr_off   <= 1'b0;
            end else if (st_r == ST_EVAL) begin
                stat.liquid    <= burst_hit;
                stat.short_det <= burst_hit;
                stat.pwr_off   <= burst_hit;
                stat.host_evt  <= burst_hit & ~stat.liquid;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_PWR_FOLLOWS: assert property (@(posedge clk) disable iff (sys_rst)
        ce && cfg.det_en && st_r == ST_EVAL && burst_hit |=> stat.pwr_off)
        else $error("power paths not cut after short");
    AST_RESTORE: assert property (@(posedge clk) disable iff (sys_rst)
        ce && cfg.det_en && st_r == ST_EVAL && !burst_hit |=> !stat.pwr_off)
        else $error("port not restored after clean burst");
    AST_PULLDOWN: assert property (@(posedge clk) disable iff (sys_rst)
        ce && !cfg.det_en |=> sense_dn == 2'h3 && sense_up == 2'h0)
        else $error("sensing not pulled down while disabled");
    AST_EVT_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
        stat.host_evt |-> stat.liquid && !$past(stat.liquid))
        else $error("host event without new liquid");
    AST_STICKY: assert property (@(posedge clk) disable iff (sys_rst)
        ce && cfg.det_en && st_r != ST_EVAL && stat.liquid |=> stat.liquid)
        else $error("liquid flag dropped outside evaluation");
    AST_MONITOR: assert property (@(posedge clk) disable iff (sys_rst)
        ce && cfg.det_en && st_r == ST_EVAL |=> st_r == ST_GAP)
        else $error("monitoring stopped after burst");
    AST_ADC_REQ: assert property (@(posedge clk) disable iff (sys_rst)
        adc_req.req |-> st_r == ST_SAMPLE)
        else $error("sample request outside sample state");
    AST_TOGGLE: assert property (@(posedge clk) disable iff (sys_rst)
        sense_up != 2'h0 |-> sense_up != 2'h3 && (sense_up ^ sense_dn) == 2'h3)
        else $error("sensing drive not exclusive per pin");
    AST_GAP_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
        ce && st_r == ST_EVAL && cfg.det_en |=> cnt_r == $past(gap_len))
        else $error("burst gap not loaded from config");
    AST_SHORT_MATCH: assert property (@(posedge clk) disable iff (sys_rst)
        stat.short_det == stat.liquid)
        else $error("short indication differs from liquid flag");
    AST_PWR_MATCH: assert property (@(posedge clk) disable iff (sys_rst)
        stat.pwr_off == stat.liquid)
        else $error("power request differs from liquid flag");
    AST_VERDICT: assert property (@(posedge clk) disable iff (sys_rst)
        ce && cfg.det_en && st_r == ST_EVAL |=> stat.liquid == $past(burst_hit))
        else $error("liquid flag not taken from burst verdict");
    AST_IDLE_OFF: assert property (@(posedge clk) disable iff (sys_rst)
        ce && !cfg.det_en |=> st_r == ST_IDLE && !adc_req.req)
        else $error("sequencer active while detection disabled");
    AST_SETTLE_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
        ce && enters(st_r, st_nxt, ST_DRIVE) |=> cnt_r == SETTLE_CNT)
        else $error("settle time not loaded on drive");
    AST_REQ_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
        ce && adc_req.req |=> !adc_req.req)
        else $error("sample request longer than one cycle");
    AST_FREEZE: assert property (@(posedge clk) disable iff (sys_rst)
        !ce |=> $stable(st_r) && $stable(cnt_r) && $stable(stat))
        else $error("state moved while clock enable low");

    COV_DETECT: cover property (@(posedge clk) stat.host_evt);
    COV_CLEAR: cover property (@(posedge clk) $fell(stat.liquid));
    COV_CORR: cover property (@(posedge clk) cfg.corr_en && stat.liquid && st_r == ST_GAP);
    COV_FREEZE: cover property (@(posedge clk) !ce && st_r == ST_GAP);
endmodule : lqdet_ctrl
`default_nettype wire

// ---- test/lqdet_adc_model.sv ----
// Behavioural ADC behind the sideband sensing circuitry
`timescale 1ns/1ns
`default_nettype none
module lqdet_adc_model (
    input  wire logic                      clk,
    input  wire lqdet_pkg::lqdet_adc_req_t req,
    input  wire logic [9:0]                lvl0,
    input  wire logic [9:0]                lvl1,
    input  wire logic [7:0]                lat,
    output var  lqdet_pkg::lqdet_adc_rsp_t rsp
);
    import lqdet_pkg::*;
    int   cnt   = 0;
    logic pin_r = 1'b0;
    initial rsp = '0;
    always @(posedge clk) begin
        rsp.valid <= 1'b0;
        // Data is only meaningful with valid, so it churns otherwise
        rsp.data <= ~rsp.data;
        if (req.req) begin
            cnt   <= int'(lat) + 1;
            pin_r <= req.pin;
        end else if (cnt == 1) begin
            rsp.valid <= 1'b1;
            rsp.data  <= pin_r ? lvl1 : lvl0;
            cnt       <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule : lqdet_adc_model
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking testbench for the liquid detection controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import lqdet_pkg::*;
    logic           clk          = 1'b0;
    logic           sys_rst      = 1'b1;
    logic           ce           = 1'b1;
    lqdet_cfg_t     cfg          = '0;
    logic [9:0]     lvl1         = 10'h050;
    lqdet_adc_rsp_t adc_rsp;
    lqdet_adc_req_t adc_req;
    logic [1:0]     sense_up;
    logic [1:0]     sense_dn;
    lqdet_stat_t    stat;
    int             miscompares  = 0;
    int             total_checks = 0;
    int             n0;
    int             n1;
    always #25 clk = ~clk;
    lqdet_ctrl dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .cfg(cfg), .adc_rsp(adc_rsp),
        .adc_req(adc_req), .sense_up(sense_up), .sense_dn(sense_dn), .stat(stat));
    lqdet_adc_model adc (.clk(clk), .req(adc_req), .lvl0(10'h050), .lvl1(lvl1),
        .lat(8'h03), .rsp(adc_rsp));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : step
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wait_req(input logic pin, output int n);
        for (n = 1; n < 5000; n++) begin
            step(1);
            if (adc_req.req === 1'b1 && adc_req.pin === pin) return;
        end
        chk("req_wait", 16'h0001, 16'h0000);
    endtask : wait_req
    task automatic wait_bit(input int b, input logic v);
        for (int i = 0; i < 5000; i++) begin
            step(1);
            if (stat[b] === v) return;
        end
        chk("stat_wait", 16'h0001, 16'h0000);
    endtask : wait_bit
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_idle;
        int reqs;
        reqs = 0;
        for (int i = 0; i < 300; i++) begin
            step(1);
            if (adc_req.req !== 1'b0 || sense_dn !== 2'h3) reqs++;
        end
        chk("idle_activity", 16'h0000, 16'(reqs));
        chk("idle_stat", 16'h0000, stat);
    endtask : t_idle
    task automatic t_toggle;
        cfg = '{det_en: 1'b1, corr_en: 1'b0, thresh: 10'h200, burst_len: 8'h00,
                burst_gap: 16'h0014};
        wait_req(1'b0, n0);
        chk("up_sbu1", 16'h0001, sense_up);
        chk("dn_sbu1", 16'h0002, sense_dn);
        wait_req(1'b1, n0);
        chk("up_sbu2", 16'h0002, sense_up);
        chk("dn_sbu2", 16'h0001, sense_dn);
        wait_req(1'b0, n0);
        chk("clean_liquid", 16'h0000, stat);
    endtask : t_toggle
    task automatic t_liquid;
        lvl1 = 10'h3ff;
        wait_bit(0, 1'b1);
        chk("evt_liquid", 16'h0001, stat.liquid);
        chk("evt_short", 16'h0001, stat.short_det);
        chk("evt_pwr_off", 16'h0001, stat.pwr_off);
        step(1);
        chk("evt_width", 16'h0000, stat.host_evt);
        wait_req(1'b0, n0);
        wait_req(1'b0, n0);
        chk("still_liquid", 16'h000e, stat);
    endtask : t_liquid
    task automatic t_corr;
        cfg.corr_en = 1'b1;
        wait_req(1'b0, n1);
        wait_req(1'b0, n1);
        chk("corr_gap", cfg.burst_gap + 16'h0001, 16'(n1 - n0));
        cfg.corr_en = 1'b0;
    endtask : t_corr
    task automatic t_clear;
        lvl1 = 10'h050;
        wait_bit(3, 1'b0);
        chk("clear_stat", 16'h0000, stat);
        ce = 1'b0;
        step(10);
        chk("freeze_stat", 16'h0000, stat);
        ce = 1'b1;
        wait_req(1'b0, n1);
        chk("freeze_gap", cfg.burst_gap + SETTLE_CNT + 16'h000c, 16'(n1 + 10));
    endtask : t_clear
    task automatic t_disable;
        lvl1 = 10'h201;
        wait_bit(0, 1'b1);
        cfg.det_en = 1'b0;
        step(2);
        chk("off_stat", 16'h0000, stat);
        chk("off_dn", 16'h0003, sense_dn);
        chk("off_up", 16'h0000, sense_up);
    endtask : t_disable
    initial begin
        step(16);
        sys_rst = 1'b0;
        chk("rst_dn", 16'h0003, sense_dn);
        chk("rst_up", 16'h0000, sense_up);
        t_idle();
        t_toggle();
        t_liquid();
        t_corr();
        t_clear();
        t_disable();
        complete_run();
    end
    initial begin
        #3000000;
        miscompares++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
